// ===== rtl/quad_uart_pin_mode_config.sv
// quad uart channels with mode straps, fifo depth selection and interrupt pin mapping
`timescale 1ns/1ns
// Summary of operation
// RULE1: mode straps 111 select standalone quad uart
// RULE2: standalone ignores pci; board ties pci inactive
// RULE3: first interrupt pin driven standalone, else open-drain
// RULE4: second pin clkrun in mini-pci, else open-drain
// RULE5: select low gives sixteen-entry fifos
// RULE6: select high gives 128-entry fifos
// RULE7: select pin level readable live by software
// RULE8: fcr bit5 with lcr bit7 forces 128
// RULE9: enhanced mode forces 128-entry fifos
// RULE10: infrared transmit when mcr bit6 and enhanced
// RULE11: infrared receive decode when infrared enabled
// RULE12: active-low carrier detect input, low means present
// RULE13: host port: 5-bit address, 8-bit data, strobes
module quad_uart_pin_mode_config #(
  parameter int BAUD  = quad_uart_pkg::BAUD_DEF,
  parameter int DEEP  = quad_uart_pkg::DEPTH_DEEP,
  parameter int SHORT = quad_uart_pkg::DEPTH_LEGACY
) (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic [2:0]                        mode_strap,
  input  wire logic                              minipci_sel,
  input  wire logic                              fifo_depth_select,
  input  wire logic [quad_uart_pkg::ADDR_W-1:0]  host_addr,
  input  wire logic [7:0]                        host_data_i,
  output logic [7:0]                             host_data_o,
  output logic                                   host_data_oe,
  input  wire logic                              host_cs_n,
  input  wire logic                              host_rd_n,
  input  wire logic                              host_wr_n,
  input  wire logic                              aux_irq,
  input  wire logic                              int_a_i,
  output logic                                   int_a_o,
  output logic                                   int_a_oe,
  input  wire logic                              int_b_i,
  output logic                                   int_b_o,
  output logic                                   int_b_oe,
  input  wire logic [quad_uart_pkg::N_CHAN-1:0]  serial_in,
  output logic [quad_uart_pkg::N_CHAN-1:0]       serial_out,
  input  wire logic [quad_uart_pkg::N_CHAN-1:0]  carrier_detect_n
);
  import quad_uart_pkg::*;

  localparam int PW     = $clog2(DEEP);
  localparam int CW     = PW + 1;
  localparam int DIV    = (CLK_HZ / (BAUD * OVERSAMPLE) < 1) ? 1 : CLK_HZ / (BAUD * OVERSAMPLE);
  localparam int DIV_W  = $clog2(DIV + 1);
  localparam logic [CW-1:0] LIM_DEEP  = CW'(DEEP);
  localparam logic [CW-1:0] LIM_SHORT = CW'(SHORT);

  logic              standalone_q;
  logic              strap_seen_q;
  host_req_t         req;
  logic [DIV_W-1:0]  div_q;
  logic              tick_q;
  logic [7:0]        rd_val [N_CHAN];
  logic [N_CHAN-1:0] irq_ch;
  logic [N_CHAN-1:0] active_ch;
  logic              irq;
  logic [1:0]        rd_ch;
  logic [REG_W-1:0]  rd_reg;

  // mode straps caught at reset release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      standalone_q <= 1'b0;
      strap_seen_q <= 1'b0;
    end else if (!strap_seen_q) begin
      standalone_q <= (mode_strap == MODE_STANDALONE); // see RULE1
      strap_seen_q <= 1'b1;
    end
  end

  // host port strobes are honoured only in standalone mode
  always_comb begin
    req.addr  = host_addr;
    req.wdata = host_data_i;
    req.wr    = standalone_q && strap_seen_q && !host_cs_n && !host_wr_n; // see RULE13 see RULE2
    req.rd    = standalone_q && strap_seen_q && !host_cs_n && !host_rd_n && host_wr_n; // see RULE13 see RULE2
  end

  // oversample tick for all channels
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(DIV - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_CHAN; gi++) begin : g_ch
      chan_cfg_t       cfg_q;
      logic [N_EV-1:0] st_q, ev_set;
      logic [7:0]      tx_mem [DEEP];
      logic [7:0]      rx_mem [DEEP];
      logic [PW-1:0]   tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
      logic [CW-1:0]   tx_cnt_q, rx_cnt_q, lim;
      logic            deep, irda, sel, wr_reg, rd_data;
      logic            tx_push, tx_pop, rx_push, rx_pop, tx_busy;
      logic            lane_go_q, tx_idle_q, carrier_q;
      logic            rx_valid;
      logic [7:0]      rx_byte;

      assign sel     = (req.addr[ADDR_W-1:REG_W] == 2'(gi));
      assign wr_reg  = req.wr && sel;
      assign rd_data = req.rd && sel && (req.addr[REG_W-1:0] == REG_DATA);
      assign deep    = fifo_depth_select | cfg_q.fcr_deep | cfg_q.enh; // see RULE6 see RULE8 see RULE9
      assign lim     = deep ? LIM_DEEP : LIM_SHORT; // see RULE5
      assign irda    = cfg_q.modem_control_reg[MCR_IRDA] & cfg_q.enh; // see RULE10 see RULE11
      assign tx_push = wr_reg && (req.addr[REG_W-1:0] == REG_DATA) && (tx_cnt_q < lim);
      assign tx_pop  = !tx_busy && !lane_go_q && (tx_cnt_q != '0);
      assign rx_push = rx_valid && (rx_cnt_q < lim);
      assign rx_pop  = rd_data && (rx_cnt_q != '0);

      // configuration registers
      always_ff @(posedge clk) begin
        if (!rstn) begin
          cfg_q <= '0;
        end else if (wr_reg) begin
          unique case (req.addr[REG_W-1:0])
            REG_LCR:      cfg_q.line_control_reg  <= req.wdata;
            REG_MCR:      cfg_q.modem_control_reg  <= req.wdata;
            REG_INT_MASK: cfg_q.mask <= req.wdata[N_EV-1:0];
            REG_ENH:      cfg_q.enh  <= req.wdata[ENH_ON]; // see RULE9
            REG_FCR: if (cfg_q.line_control_reg[LCR_DLAB]) cfg_q.fcr_deep <= req.wdata[FCR_DEEP]; // see RULE8
            default: ;
          endcase
        end
      end

      // transmit fifo
      always_ff @(posedge clk) begin
        if (!rstn || (wr_reg && req.addr[REG_W-1:0] == REG_FCR && req.wdata[FCR_TX_RST])) begin
          tx_wp_q  <= '0;
          tx_rp_q  <= '0;
          tx_cnt_q <= '0;
        end else begin
          if (tx_push) begin
            tx_mem[tx_wp_q] <= req.wdata;
            tx_wp_q <= (CW'(tx_wp_q) == lim - 1'b1) ? '0 : tx_wp_q + 1'b1;
          end
          if (tx_pop) tx_rp_q <= (CW'(tx_rp_q) == lim - 1'b1) ? '0 : tx_rp_q + 1'b1;
          tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
        end
      end

      // receive fifo
      always_ff @(posedge clk) begin
        if (!rstn || (wr_reg && req.addr[REG_W-1:0] == REG_FCR && req.wdata[FCR_RX_RST])) begin
          rx_wp_q  <= '0;
          rx_rp_q  <= '0;
          rx_cnt_q <= '0;
        end else begin
          if (rx_push) begin
            rx_mem[rx_wp_q] <= rx_byte;
            rx_wp_q <= (CW'(rx_wp_q) == lim - 1'b1) ? '0 : rx_wp_q + 1'b1;
          end
          if (rx_pop) rx_rp_q <= (CW'(rx_rp_q) == lim - 1'b1) ? '0 : rx_rp_q + 1'b1;
          rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
        end
      end

      // one-cycle launch into the lane
      always_ff @(posedge clk) begin
        if (!rstn) begin
          lane_go_q <= 1'b0;
          tx_idle_q <= 1'b1;
          carrier_q <= 1'b0;
        end else begin
          lane_go_q <= tx_pop;
          tx_idle_q <= !tx_busy && (tx_cnt_q == '0);
          carrier_q <= !carrier_detect_n[gi]; // see RULE12
        end
      end

      serial_lane u_lane (
        .clk      (clk),
        .rstn     (rstn),
        .tick     (tick_q),
        .irda     (irda),
        .tx_valid (lane_go_q),
        .tx_data  (tx_mem[tx_rp_q == '0 ? PW'(lim - 1'b1) : tx_rp_q - 1'b1]),
        .tx_busy  (tx_busy),
        .rx_valid (rx_valid),
        .rx_data  (rx_byte),
        .sin      (serial_in[gi]),
        .sout     (serial_out[gi])
      );

      // events: set wins over a write-one clear
      always_comb begin
        ev_set              = '0;
        ev_set[EV_RX_AVAIL] = rx_push;
        ev_set[EV_TX_EMPTY] = !tx_idle_q && !tx_busy && (tx_cnt_q == '0);
        ev_set[EV_CARRIER]  = carrier_q != !carrier_detect_n[gi]; // see RULE12
        ev_set[EV_OVERRUN]  = rx_valid && !rx_push;
      end

      always_ff @(posedge clk) begin
        if (!rstn) st_q <= '0;
        else if (wr_reg && req.addr[REG_W-1:0] == REG_INT_STAT) st_q <= (st_q & ~req.wdata[N_EV-1:0]) | ev_set;
        else st_q <= st_q | ev_set;
      end

      // register readback
      always_comb begin
        rd_val[gi] = '0;
        unique case (req.addr[REG_W-1:0])
          REG_DATA:     rd_val[gi] = (rx_cnt_q != '0) ? rx_mem[rx_rp_q] : RST_BYTE;
          REG_INT_MASK: rd_val[gi][N_EV-1:0] = cfg_q.mask;
          REG_FCR:      rd_val[gi][FCR_DEEP] = cfg_q.fcr_deep;
          REG_LCR:      rd_val[gi] = cfg_q.line_control_reg;
          REG_MCR:      rd_val[gi] = cfg_q.modem_control_reg;
          REG_LSR: begin
            rd_val[gi][LSR_RX_AVAIL] = (rx_cnt_q != '0);
            rd_val[gi][LSR_TX_EMPTY] = tx_idle_q;
            rd_val[gi][LSR_CARRIER]  = !carrier_detect_n[gi]; // see RULE12
            rd_val[gi][LSR_DEEP]     = deep;
            rd_val[gi][LSR_SEL_PIN]  = fifo_depth_select; // see RULE7
            rd_val[gi][LSR_TX_FULL]  = (tx_cnt_q >= lim);
          end
          REG_INT_STAT: rd_val[gi][N_EV-1:0] = st_q;
          REG_ENH:      rd_val[gi][ENH_ON] = cfg_q.enh;
          default:      rd_val[gi] = '0;
        endcase
      end

      assign irq_ch[gi]    = |(st_q & cfg_q.mask);
      assign active_ch[gi] = !tx_idle_q;
    end
  endgenerate

  assign irq    = |irq_ch;
  assign rd_ch  = req.addr[ADDR_W-1:REG_W];
  assign rd_reg = req.addr[REG_W-1:0];

  // read data stands in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_data_o  <= RST_BYTE;
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= req.rd; // see RULE13
      host_data_o  <= req.rd ? rd_val[rd_ch] : RST_BYTE;
    end
  end

  // first interrupt pin
  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_a_o  <= 1'b0;
      int_a_oe <= 1'b0;
    end else if (standalone_q) begin
      int_a_o  <= irq; // see RULE3
      int_a_oe <= 1'b1;
    end else begin
      int_a_o  <= 1'b0; // see RULE3
      int_a_oe <= irq;
    end
  end

  // second interrupt pin or clock-run line
  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_b_o  <= 1'b0;
      int_b_oe <= 1'b0;
    end else if (minipci_sel && !standalone_q) begin
      int_b_o  <= 1'b0;
      int_b_oe <= int_b_i && (|active_ch || irq); // see RULE4
    end else begin
      int_b_o  <= 1'b0;
      int_b_oe <= aux_irq && !standalone_q; // see RULE4
    end
  end
endmodule : quad_uart_pin_mode_config

// ===== rtl/quad_uart_pkg.sv
// constants, register map and carrier types for the quad uart pin/mode block
package quad_uart_pkg;
  localparam int          CLK_HZ        = 25000000;
  localparam int          BAUD_DEF      = 115200;
  localparam int          OVERSAMPLE    = 16;
  localparam int          N_CHAN        = 4;
  localparam int          DEPTH_LEGACY  = 16;
  localparam int          DEPTH_DEEP    = 128;
  localparam logic [2:0]  MODE_STANDALONE = 3'h7;
  // host port: addr[4:3] channel, addr[2:0] register
  localparam int          ADDR_W        = 5;
  localparam int          REG_W         = 3;
  localparam logic [2:0]  REG_DATA      = 3'h0;
  localparam logic [2:0]  REG_INT_MASK  = 3'h1;
  localparam logic [2:0]  REG_FCR       = 3'h2;
  localparam logic [2:0]  REG_LCR       = 3'h3;
  localparam logic [2:0]  REG_MCR       = 3'h4;
  localparam logic [2:0]  REG_LSR       = 3'h5;
  localparam logic [2:0]  REG_INT_STAT  = 3'h6;
  localparam logic [2:0]  REG_ENH       = 3'h7;
  // field positions
  localparam int          LCR_DLAB      = 7;
  localparam int          FCR_RX_RST    = 1;
  localparam int          FCR_TX_RST    = 2;
  localparam int          FCR_DEEP      = 5;
  localparam int          MCR_IRDA      = 6;
  localparam int          ENH_ON        = 0;
  localparam int          LSR_RX_AVAIL  = 0;
  localparam int          LSR_TX_EMPTY  = 1;
  localparam int          LSR_CARRIER   = 2;
  localparam int          LSR_DEEP      = 3;
  localparam int          LSR_SEL_PIN   = 4;
  localparam int          LSR_TX_FULL   = 5;
  localparam int          EV_RX_AVAIL   = 0;
  localparam int          EV_TX_EMPTY   = 1;
  localparam int          EV_CARRIER    = 2;
  localparam int          EV_OVERRUN    = 3;
  localparam int          N_EV          = 4;
  // serial frame: start, eight data, stop
  localparam int          FRAME_BITS    = 10;
  localparam int          IRDA_PULSE    = 3;
  localparam int          MID_PHASE     = 7;
  localparam logic [7:0]  RST_BYTE      = 8'h00;

  typedef struct packed {
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [N_EV-1:0] mask;
    logic       fcr_deep;
    logic       enh;
  } chan_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } host_req_t;
endpackage : quad_uart_pkg

// ===== rtl/serial_lane.sv
// one channel's serialiser and deserialiser with infrared pulse coding
`timescale 1ns/1ns
module serial_lane (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       tick,
  input  wire logic       irda,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_busy,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       sin,
  output logic            sout
);
  import quad_uart_pkg::*;

  typedef enum logic [1:0] {
    LN_IDLE  = 2'b00,
    LN_SHIFT = 2'b01
  } lane_st_t;

  lane_st_t   tx_st_q, rx_st_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bit_q, tx_ph_q, rx_bit_q, rx_ph_q;
  logic [9:0] rx_sh_q;
  logic       rx_mid_q, rx_low_q, rx_bitval;
  logic       line_low;

  // infrared input: a high pulse means a zero bit
  assign line_low  = irda ? sin : ~sin; // see RULE11
  assign rx_bitval = irda ? ~(rx_low_q | line_low) : rx_mid_q; // see RULE11
  assign tx_busy   = (tx_st_q != LN_IDLE) | tx_valid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_st_q  <= LN_IDLE;
      tx_sh_q  <= '1;
      tx_bit_q <= '0;
      tx_ph_q  <= '0;
    end else begin
      unique case (tx_st_q)
        LN_IDLE: if (tx_valid) begin
          tx_sh_q  <= {1'b1, tx_data, 1'b0};
          tx_bit_q <= '0;
          tx_ph_q  <= '0;
          tx_st_q  <= LN_SHIFT;
        end
        LN_SHIFT: if (tick) begin
          tx_ph_q <= tx_ph_q + 4'h1;
          if (tx_ph_q == 4'(OVERSAMPLE - 1)) begin
            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == 4'(FRAME_BITS - 1)) tx_st_q <= LN_IDLE;
          end
        end
      endcase
    end
  end

  // serial or infrared pulse output, idle high or idle low
  always_ff @(posedge clk) begin
    if (!rstn) sout <= 1'b1;
    else if (irda) sout <= (tx_st_q == LN_SHIFT) && !tx_sh_q[0] && (tx_ph_q < 4'(IRDA_PULSE)); // see RULE10
    else sout <= (tx_st_q == LN_SHIFT) ? tx_sh_q[0] : 1'b1; // see RULE10
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_st_q  <= LN_IDLE;
      rx_sh_q  <= '0;
      rx_bit_q <= '0;
      rx_ph_q  <= '0;
      rx_mid_q <= 1'b1;
      rx_low_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= RST_BYTE;
    end else begin
      rx_valid <= 1'b0;
      unique case (rx_st_q)
        LN_IDLE: if (tick && line_low) begin
          rx_st_q  <= LN_SHIFT;
          rx_bit_q <= '0;
          rx_ph_q  <= 4'h1;
          rx_low_q <= 1'b1;
          rx_mid_q <= 1'b0;
        end
        LN_SHIFT: if (tick) begin
          rx_ph_q <= rx_ph_q + 4'h1;
          if (line_low) rx_low_q <= 1'b1;
          if (rx_ph_q == 4'(MID_PHASE)) rx_mid_q <= ~line_low;
          if (rx_ph_q == 4'(OVERSAMPLE - 1)) begin
            rx_low_q <= 1'b0;
            rx_sh_q  <= {rx_bitval, rx_sh_q[9:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && rx_bitval) rx_st_q <= LN_IDLE;
            if (rx_bit_q == 4'(FRAME_BITS - 1)) begin
              rx_st_q  <= LN_IDLE;
              rx_valid <= rx_bitval;
              rx_data  <= rx_sh_q[9:2];
            end
          end
        end
      endcase
    end
  end
endmodule : serial_lane

// ===== sim/quad_uart_pin_mode_config_chk.sv
// port checker for the quad uart pin and mode block
`timescale 1ns/1ns
module quad_uart_pin_mode_config_chk
  import quad_uart_pkg::*;
#(
  parameter int BAUD  = BAUD_DEF,
  parameter int DEEP  = DEPTH_DEEP,
  parameter int SHORT = DEPTH_LEGACY
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [2:0] mode_strap,
  input wire logic       minipci_sel,
  input wire logic       host_cs_n,
  input wire logic       host_rd_n,
  input wire logic       host_wr_n,
  input wire logic [7:0] host_data_o,
  input wire logic       host_data_oe,
  input wire logic       aux_irq,
  input wire logic       int_a_o,
  input wire logic       int_a_oe,
  input wire logic       int_b_o,
  input wire logic       int_b_oe,
  input wire logic [3:0] serial_out
);
  logic cap_q;
  logic sa_q;
  wire  rd_req = !host_cs_n && !host_rd_n && host_wr_n;
  // mirror of the strap capture at the first edge out of reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cap_q <= 1'b0;
      sa_q  <= 1'b0;
    end else if (!cap_q) begin
      cap_q <= 1'b1;
      sa_q  <= (mode_strap == MODE_STANDALONE);
    end
  end
  a_read_answer: assert property (@(posedge clk) disable iff (!rstn)
    sa_q && rd_req |=> host_data_oe) else $error("read not answered");
  a_answer_cause: assert property (@(posedge clk) disable iff (!rstn)
    host_data_oe |-> $past(rd_req)) else $error("data driven without read");
  a_data_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !host_data_oe |-> host_data_o == 8'h00) else $error("read data outside answer");
  a_pci_ignore: assert property (@(posedge clk) disable iff (!rstn)
    cap_q && !sa_q |-> !host_data_oe) else $error("host port active outside standalone");
  a_int_a_driven: assert property (@(posedge clk) disable iff (!rstn)
    sa_q && $past(sa_q, 2) |-> int_a_oe) else $error("pin a not driven");
  a_int_a_od: assert property (@(posedge clk) disable iff (!rstn)
    cap_q && !sa_q |-> !int_a_o) else $error("pin a not open drain");
  a_int_b_low: assert property (@(posedge clk) disable iff (!rstn)
    !int_b_o) else $error("pin b driven high");
  a_int_b_aux: assert property (@(posedge clk) disable iff (!rstn)
    cap_q && $past(cap_q) && !sa_q && !minipci_sel && !$past(minipci_sel) |-> int_b_oe == $past(aux_irq))
    else $error("pin b does not follow aux interrupt");
  a_sout_idle: assert property (@(posedge clk)
    !rstn |=> serial_out == 4'hf) else $error("serial out not idle after reset");
endmodule : quad_uart_pin_mode_config_chk

bind quad_uart_pin_mode_config quad_uart_pin_mode_config_chk #(.BAUD(BAUD), .DEEP(DEEP), .SHORT(SHORT)) chk (
  .clk(clk), .rstn(rstn), .mode_strap(mode_strap), .minipci_sel(minipci_sel), .host_cs_n(host_cs_n),
  .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_data_o(host_data_o), .host_data_oe(host_data_oe),
  .aux_irq(aux_irq), .int_a_o(int_a_o), .int_a_oe(int_a_oe), .int_b_o(int_b_o), .int_b_oe(int_b_oe),
  .serial_out(serial_out));

// ===== sim/quad_uart_pin_mode_config_test.sv
// self-checking bench for the quad uart pin and mode block
`timescale 1ns/1ns
module quad_uart_pin_mode_config_test;
  import quad_uart_pkg::*;
  localparam int BAUD_T = 781250;
  localparam int BIT_T  = CLK_HZ / (BAUD_T * OVERSAMPLE) * OVERSAMPLE;
  localparam int SHORT_T = 4;
  localparam int DEEP_T  = 8;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [2:0]        mode_strap = 3'h0;
  logic              minipci_sel = 1'b0;
  logic              fifo_depth_select = 1'b0;
  logic [ADDR_W-1:0] host_addr = 5'h00;
  logic [7:0]        wdata_q = 8'h00;
  logic              host_cs_n = 1'b1;
  logic              host_rd_n = 1'b1;
  logic              host_wr_n = 1'b1;
  logic              aux_irq = 1'b0;
  logic [3:0]        ir_mode = 4'h0;
  logic [7:0]        host_data_o;
  logic              host_data_oe;
  logic              int_a_o;
  logic              int_a_oe;
  logic              int_b_o;
  logic              int_b_oe;
  logic [3:0]        serial_in;
  logic [3:0]        serial_out;
  logic [3:0]        carrier_detect_n;
  logic [7:0]        d;
  logic              oe;
  int                fail_count = 0;
  int                check_count = 0;
  int                cyc = 0;
  wire  [7:0]        host_data_i = host_data_oe ? host_data_o : wdata_q;

  quad_uart_pin_mode_config #(.BAUD(BAUD_T), .DEEP(DEEP_T), .SHORT(SHORT_T)) dut (
    .clk(clk), .rstn(rstn), .mode_strap(mode_strap), .minipci_sel(minipci_sel),
    .fifo_depth_select(fifo_depth_select), .host_addr(host_addr), .host_data_i(host_data_i),
    .host_data_o(host_data_o), .host_data_oe(host_data_oe), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .aux_irq(aux_irq), .int_a_i(int_a_oe ? int_a_o : 1'b1), .int_a_o(int_a_o),
    .int_a_oe(int_a_oe), .int_b_i(int_b_oe ? int_b_o : 1'b1), .int_b_o(int_b_o), .int_b_oe(int_b_oe),
    .serial_in(serial_in), .serial_out(serial_out), .carrier_detect_n(carrier_detect_n));
  serial_peer #(.BIT(BIT_T), .PULSE(IRDA_PULSE * BIT_T / OVERSAMPLE)) peer (
    .clk(clk), .serial_out(serial_out), .ir_mode(ir_mode), .serial_in(serial_in),
    .carrier_detect_n(carrier_detect_n));

  always #20 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] ch, input logic [2:0] rg, input logic [7:0] v);
    @(posedge clk);
    host_cs_n <= 1'b0;
    host_wr_n <= 1'b0;
    host_addr <= {ch, rg};
    wdata_q   <= v;
    @(posedge clk);
    host_cs_n <= 1'b1;
    host_wr_n <= 1'b1;
    wdata_q   <= ~v;
  endtask : wr

  task automatic rd(input logic [1:0] ch, input logic [2:0] rg);
    @(posedge clk);
    host_cs_n <= 1'b0;
    host_rd_n <= 1'b0;
    host_addr <= {ch, rg};
    @(posedge clk);
    host_cs_n <= 1'b1;
    host_rd_n <= 1'b1;
    #1;
    d  = host_data_o;
    oe = host_data_oe;
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    int n;
    repeat (10) @(posedge clk);
    rstn    <= 1'b1;
    aux_irq <= 1'b1;
    settle();
    check({7'h0, int_b_oe}, 8'h01);
    rd(2'h0, REG_LSR);
    check({7'h0, oe}, 8'h00);
    @(posedge clk);
    minipci_sel <= 1'b1;
    settle();
    check({7'h0, int_b_oe}, 8'h00);
    $display("test pci modes done");
    @(posedge clk);
    rstn        <= 1'b0;
    aux_irq     <= 1'b0;
    minipci_sel <= 1'b0;
    mode_strap  <= MODE_STANDALONE;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    settle();
    check({int_a_oe, int_a_o}, 8'h02);
    rd(2'h0, REG_LSR);
    check(d, 8'h02);
    for (int s = 0; s < 2; s++) begin
      n = s ? DEEP_T : SHORT_T;
      @(posedge clk);
      fifo_depth_select <= s[0];
      rd(2'h0, REG_LSR);
      check({7'h0, d[LSR_SEL_PIN]}, {7'h0, s[0]});
      check({7'h0, d[LSR_DEEP]}, {7'h0, s[0]});
      wr(2'h0, REG_FCR, 8'h02);
      wr(2'h0, REG_INT_STAT, 8'h0f);
      for (int i = 0; i <= n; i++) begin
        if (i == n) begin
          rd(2'h0, REG_INT_STAT);
          check({7'h0, d[EV_OVERRUN]}, 8'h00);
        end
        peer.send(0, 8'h30 + i[7:0]);
      end
      settle();
      rd(2'h0, REG_INT_STAT);
      check({7'h0, d[EV_OVERRUN]}, 8'h01);
      rd(2'h0, REG_DATA);
      check(d, 8'h30);
      wr(2'h0, REG_FCR, 8'h02);
    end
    @(posedge clk);
    fifo_depth_select <= 1'b0;
    $display("test fifo depth done");
    wr(2'h0, REG_INT_MASK, 8'h01);
    settle();
    check({7'h0, int_a_o}, 8'h01);
    wr(2'h0, REG_INT_MASK, 8'h00);
    settle();
    check({7'h0, int_a_o}, 8'h00);
    wr(2'h0, REG_INT_MASK, 8'h01);
    wr(2'h0, REG_INT_STAT, 8'h0f);
    settle();
    check({7'h0, int_a_o}, 8'h00);
    wr(2'h0, REG_INT_MASK, 8'h00);
    $display("test interrupt done");
    wr(2'h1, REG_FCR, 8'h20);
    rd(2'h1, REG_LSR);
    check({7'h0, d[LSR_DEEP]}, 8'h00);
    wr(2'h1, REG_LCR, 8'h80);
    wr(2'h1, REG_FCR, 8'h20);
    wr(2'h1, REG_LCR, 8'h00);
    rd(2'h1, REG_LSR);
    check({7'h0, d[LSR_DEEP]}, 8'h01);
    wr(2'h2, REG_ENH, 8'h01);
    rd(2'h2, REG_LSR);
    check({7'h0, d[LSR_DEEP]}, 8'h01);
    $display("test depth override done");
    @(posedge clk);
    peer.cd_n_q[3] <= 1'b0;
    settle();
    rd(2'h3, REG_LSR);
    check({7'h0, d[LSR_CARRIER]}, 8'h01);
    rd(2'h3, REG_INT_STAT);
    check({7'h0, d[EV_CARRIER]}, 8'h01);
    $display("test carrier done");
    wr(2'h0, REG_DATA, 8'h5a);
    peer.recv(0, 1'b0, d);
    check(d, 8'h5a);
    wr(2'h2, REG_MCR, 8'h40);
    ir_mode <= 4'h4;
    repeat (12 * BIT_T) @(posedge clk);
    wr(2'h2, REG_FCR, 8'h02);
    wr(2'h2, REG_DATA, 8'hc3);
    peer.recv(2, 1'b1, d);
    check(d, 8'hc3);
    peer.send(2, 8'h96);
    settle();
    rd(2'h2, REG_DATA);
    check(d, 8'h96);
    $display("test serial lines done");
    tally_and_finish();
  end
endmodule : quad_uart_pin_mode_config_test

// ===== sim/serial_peer.sv
// remote serial equipment model: nrz or infrared frames and carrier detect
`timescale 1ns/1ns
module serial_peer #(
  parameter int BIT   = 32,
  parameter int PULSE = 6
) (
  input  wire logic       clk,
  input  wire logic [3:0] serial_out,
  input  wire logic [3:0] ir_mode,
  output logic [3:0]      serial_in,
  output logic [3:0]      carrier_detect_n
);
  logic [3:0] nrz_q = 4'hf;
  logic [3:0] ir_q  = 4'h0;
  logic [3:0] cd_n_q = 4'hf;
  assign serial_in        = (ir_mode & ir_q) | (~ir_mode & nrz_q);
  assign carrier_detect_n = cd_n_q;

  // start, eight data lsb first, stop; infrared zero is a short high pulse
  task automatic send(input int ch, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      nrz_q[ch] <= f[i];
      ir_q[ch]  <= ~f[i];
      repeat (PULSE) @(posedge clk);
      ir_q[ch]  <= 1'b0;
      repeat (BIT - PULSE - 1) @(posedge clk);
    end
  endtask : send

  task automatic recv(input int ch, input bit ir, output logic [7:0] b);
    int n;
    n = 0;
    b = 8'h00;
    // sample on the falling edge, clear of the edge that launches serial_out
    while (serial_out[ch] !== ir && n < 4000) begin
      @(negedge clk);
      n++;
    end
    repeat (ir ? 2 : BIT / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge clk);
      b[i] = ir ? ~serial_out[ch] : serial_out[ch];
    end
  endtask : recv
endmodule : serial_peer
